// [hdl/svwd_top.v]
// supervisor: watchdog, power reset stretch, memory select gate, power-fail warning
`timescale 1ns/10ps
`include "svwd_regs.vh"
module svwd_top
#(
   parameter LONG_PULSE   = 0,
   parameter T_LONG_CYC   = `SVWD_T_LONG_MS * (`SVWD_CLK_HZ / 1000),
   parameter T_SHORT_CYC  = `SVWD_T_SHORT_MS * (`SVWD_CLK_HZ / 1000),
   parameter P_STD_CYC    = `SVWD_PULSE_STD_MS * (`SVWD_CLK_HZ / 1000),
   parameter P_LONG_CYC   = `SVWD_PULSE_LONG_MS * (`SVWD_CLK_HZ / 1000),
   parameter CW           = 26
)
(
   input  wire sys_clk_i,
   input  wire reset_n_i,
   input  wire clk_en_i,
   input  wire watchdog_kick_in_i,
   input  wire kick_floating_i,
   input  wire supply_low_i,
   input  wire backup_active_i,
   input  wire power_fail_sense_in_i,
   input  wire mem_select_in_n_i,
   input  wire timebase_select_i,
   input  wire timebase_input_i,
   input  wire timebase_strap_short_i,
   output wire reset_n_o,
   output wire reset_o,
   output wire watchdog_expired_n_o,
   output wire power_fail_warn_n_o,
   output wire mem_select_gated_n_o,
   output wire irq_o,
   input  wire [3:0] reg_addr_i,
   input  wire [7:0] reg_wdata_i,
   input  wire reg_wr_i,
   input  wire reg_rd_i,
   output reg  [7:0] reg_rdata_o
);
   ////////////////////////////////////////////////////////////////////
   // register offsets
   localparam [3:0] A_STATUS = `SVWD_A_STATUS;
   localparam [3:0] A_MASK   = `SVWD_A_MASK;
   localparam [3:0] A_STATE  = `SVWD_A_STATE;
   // 32-bit copies, cut to the counter width on purpose
   localparam [31:0] W_LONG  = T_LONG_CYC;
   localparam [31:0] W_SHORT = T_SHORT_CYC;
   localparam [31:0] W_PSTD  = P_STD_CYC;
   localparam [31:0] W_PLONG = P_LONG_CYC;
   localparam [31:0] W_ETO   = `SVWD_EXT_TIMEOUT;
   localparam [31:0] W_EFST  = `SVWD_EXT_FIRST;
   localparam [31:0] W_EPS   = `SVWD_EXT_PULSE_STD;
   localparam [31:0] W_EPL   = `SVWD_EXT_PULSE_LONG;
   localparam [CW-1:0] C_LONG  = W_LONG[CW-1:0];
   localparam [CW-1:0] C_SHORT = W_SHORT[CW-1:0];
   localparam [CW-1:0] C_PSTD  = W_PSTD[CW-1:0];
   localparam [CW-1:0] C_PLONG = W_PLONG[CW-1:0];
   localparam [CW-1:0] C_ETO   = W_ETO[CW-1:0];
   localparam [CW-1:0] C_EFST  = W_EFST[CW-1:0];
   localparam [CW-1:0] C_EPS   = W_EPS[CW-1:0];
   localparam [CW-1:0] C_EPL   = W_EPL[CW-1:0];

   ////////////////////////////////////////////////////////////////////
   // input synchronisers
   wire kick_lvl;
   wire kick_edge;
   wire tb_lvl;
   wire tb_edge;
   wire tb_rise;
   svwd_edge_sync u_kick
   (
      .sys_clk_i (sys_clk_i),
      .reset_n_i (reset_n_i),
      .clk_en_i  (clk_en_i),
      .din_i     (watchdog_kick_in_i),
      .level_o   (kick_lvl),
      .edge_o    (kick_edge)
   );
   svwd_edge_sync u_tb
   (
      .sys_clk_i (sys_clk_i),
      .reset_n_i (reset_n_i),
      .clk_en_i  (clk_en_i),
      .din_i     (timebase_input_i),
      .level_o   (tb_lvl),
      .edge_o    (tb_edge)
   );
   assign tb_rise = tb_edge & tb_lvl;

   ////////////////////////////////////////////////////////////////////
   // timebase choice: external clock counts its rising edges
   wire ext_mode = ~timebase_select_i;
   wire tick     = ext_mode ? tb_rise : clk_en_i;
   wire svc_evt  = kick_edge & ~kick_floating_i & ~backup_active_i;
   wire wd_on    = ~kick_floating_i & ~backup_active_i & ~supply_low_i;

   reg  [1:0]    state_q;
   reg  [CW-1:0] cnt_q;
   reg           first_q;
   reg           expired_q;
   reg  [CW-1:0] pwr_cnt_q;
   reg           pwr_hold_q;

   // timeout and pulse lengths per mode
   wire [CW-1:0] int_to  = timebase_strap_short_i ? C_SHORT : C_LONG;
   wire [CW-1:0] to_len  = ext_mode ? (first_q ? C_EFST : C_ETO) : int_to;
   wire [CW-1:0] int_pl  = (LONG_PULSE != 0) ? C_PLONG : C_PSTD;
   wire [CW-1:0] ext_pl  = (LONG_PULSE != 0) ? C_EPL : C_EPS;
   wire [CW-1:0] pl_len  = ext_mode ? ext_pl : int_pl;
   wire          to_evt  = (state_q == `SVWD_ST_WAIT) & tick & (cnt_q + 1'b1 >= to_len);

   ////////////////////////////////////////////////////////////////////
   // watchdog state machine
   always @(posedge sys_clk_i)
   begin
      if (!reset_n_i)
      begin
         state_q   <= `SVWD_ST_IDLE;
         cnt_q     <= {CW{1'b0}};
         first_q   <= 1'b1;
         expired_q <= 1'b0;
      end
      else if (clk_en_i)
      begin
         if (!wd_on)
         begin
            state_q   <= `SVWD_ST_IDLE;
            cnt_q     <= {CW{1'b0}};
            first_q   <= 1'b1;
            if (supply_low_i | backup_active_i)
               expired_q <= 1'b0;
         end
         else if (svc_evt)
         begin
            // restart count, release expired flag
            state_q   <= `SVWD_ST_WAIT;
            cnt_q     <= {CW{1'b0}};
            expired_q <= 1'b0;
            if (state_q != `SVWD_ST_IDLE)
               first_q <= 1'b0;
         end
         else
         begin
            case (state_q)
               `SVWD_ST_IDLE:
               begin
                  state_q <= `SVWD_ST_WAIT;
                  cnt_q   <= {CW{1'b0}};
               end
               `SVWD_ST_WAIT:
               begin
                  if (to_evt)
                  begin
                     state_q   <= `SVWD_ST_PULSE;
                     cnt_q     <= {CW{1'b0}};
                     expired_q <= 1'b1;
                  end
                  else if (tick)
                     cnt_q <= cnt_q + 1'b1;
               end
               `SVWD_ST_PULSE:
               begin
                  if (tick & (cnt_q + 1'b1 >= pl_len))
                  begin
                     state_q <= `SVWD_ST_WAIT;
                     cnt_q   <= {CW{1'b0}};
                     first_q <= 1'b0;
                  end
                  else if (tick)
                     cnt_q <= cnt_q + 1'b1;
               end
               default:
               begin
                  state_q <= `SVWD_ST_IDLE;
                  cnt_q   <= {CW{1'b0}};
               end
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // power reset: hold while low, stretch after recovery
   always @(posedge sys_clk_i)
   begin
      if (!reset_n_i)
      begin
         pwr_hold_q <= 1'b1;
         pwr_cnt_q  <= {CW{1'b0}};
      end
      else if (clk_en_i)
      begin
         if (supply_low_i | backup_active_i)
         begin
            pwr_hold_q <= 1'b1;
            pwr_cnt_q  <= {CW{1'b0}};
         end
         else if (pwr_hold_q)
         begin
            if (pwr_cnt_q + 1'b1 >= int_pl)
               pwr_hold_q <= 1'b0;
            else
               pwr_cnt_q <= pwr_cnt_q + 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // output pins
   wire rst_act = pwr_hold_q | (state_q == `SVWD_ST_PULSE);
   assign reset_n_o = ~rst_act;
   assign reset_o   = rst_act;
   assign watchdog_expired_n_o = ~expired_q;
   assign power_fail_warn_n_o  = ~(power_fail_sense_in_i | backup_active_i);
   assign mem_select_gated_n_o = mem_select_in_n_i | supply_low_i | backup_active_i;

   ////////////////////////////////////////////////////////////////////
   // interrupt status: bit0 timeout, bit1 supply low, bit2 power-fail
   reg  [2:0] sts_q;
   reg  [2:0] mask_q;
   reg        exp_d1_q;
   reg        low_d1_q;
   reg        pf_d1_q;
   wire [2:0] evt = {power_fail_sense_in_i & ~pf_d1_q,
                     supply_low_i & ~low_d1_q,
                     expired_q & ~exp_d1_q};
   wire       wr_sts = reg_wr_i & (reg_addr_i == A_STATUS);
   always @(posedge sys_clk_i)
   begin
      if (!reset_n_i)
      begin
         sts_q       <= 3'h0;
         mask_q      <= 3'h0;
         exp_d1_q    <= 1'b0;
         low_d1_q    <= 1'b0;
         pf_d1_q     <= 1'b0;
         reg_rdata_o <= 8'h00;
      end
      else if (clk_en_i)
      begin
         exp_d1_q <= expired_q;
         low_d1_q <= supply_low_i;
         pf_d1_q  <= power_fail_sense_in_i;
         // set wins over write-one clear
         sts_q <= (sts_q & ~(wr_sts ? reg_wdata_i[2:0] : 3'h0)) | evt;
         if (reg_wr_i & (reg_addr_i == A_MASK))
            mask_q <= reg_wdata_i[2:0];
         reg_rdata_o <= 8'h00;
         if (reg_rd_i)
         begin
            case (reg_addr_i)
               A_STATUS: reg_rdata_o <= {5'h00, sts_q};
               A_MASK:   reg_rdata_o <= {5'h00, mask_q};
               A_STATE:  reg_rdata_o <= {2'h0, first_q, rst_act, expired_q, state_q, wd_on};
               default:  reg_rdata_o <= 8'h00;
            endcase
         end
      end
   end
   assign irq_o = |(sts_q & mask_q);
endmodule

// [hdl/svwd_regs.vh]
// constants for the supervisor watchdog, reset generator and chip-enable gate
// Summary of operation
// - missed kick: reset pulse of 50 ms, or 200 ms on long-pulse variant.
// - kick idle: repeat reset pulse after each timeout (1.6 s or 100 ms by strap) until a new kick edge.
// - on timeout expired flag goes low, stays low until next kick edge.
// - floating kick input disables watchdog, no timeout resets.
// - reset output held asserted while supply-low indication is present.
// - after supply recovers, reset held a further 50 ms or 200 ms.
// - active-high reset output is always complement of active-low reset.
// - supply good: gated memory select follows memory select input.
// - supply low: gated memory select forced high whatever its input.
// - backup active: gated memory select held high.
// - power-fail warning low whenever sense comparator reports below 1.3 V.
// - timebase select low uses external timebase pin, high uses internal oscillator.
// - internal oscillator: timeout 100 ms or 1.6 s by timebase strap.
// - external clock: timeout 1024, first 4096, pulse 512 or 2048 clocks.
// - expired flag forced high whenever supply is below threshold.
// - backup: ignore kick, select, timebase; hold reset and warning low.
`ifndef SVWD_REGS_VH
`define SVWD_REGS_VH
`define SVWD_CLK_HZ         20000000
`define SVWD_T_LONG_MS      1600
`define SVWD_T_SHORT_MS     100
`define SVWD_PULSE_STD_MS   50
`define SVWD_PULSE_LONG_MS  200
`define SVWD_EXT_TIMEOUT    1024
`define SVWD_EXT_FIRST      4096
`define SVWD_EXT_PULSE_STD  512
`define SVWD_EXT_PULSE_LONG 2048
`define SVWD_ST_IDLE        2'h0
`define SVWD_ST_WAIT        2'h1
`define SVWD_ST_PULSE       2'h2
`define SVWD_A_STATUS       4'h0
`define SVWD_A_MASK         4'h1
`define SVWD_A_STATE        4'h2
`endif

// [hdl/svwd_edge_sync.v]
// two-stage synchroniser with edge detect for one input
`timescale 1ns/10ps
module svwd_edge_sync
(
   input  wire sys_clk_i,
   input  wire reset_n_i,
   input  wire clk_en_i,
   input  wire din_i,
   output wire level_o,
   output wire edge_o
);
   reg meta_q;
   reg sync_q;
   reg last_q;
   // first stage read only by second stage
   always @(posedge sys_clk_i)
   begin
      if (!reset_n_i)
      begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
         last_q <= 1'b0;
      end
      else if (clk_en_i)
      begin
         meta_q <= din_i;
         sync_q <= meta_q;
         last_q <= sync_q;
      end
   end
   assign level_o = sync_q;
   assign edge_o  = clk_en_i & (sync_q ^ last_q);
endmodule

// [tb/svwd_props.sv]
// assertions on the supervisor ports
`timescale 1ns/10ps
module svwd_props
#(
   parameter int P_STD_CYC = 20
)
(
   input wire sys_clk_i,
   input wire reset_n_i,
   input wire watchdog_kick_in_i,
   input wire kick_floating_i,
   input wire supply_low_i,
   input wire backup_active_i,
   input wire power_fail_sense_in_i,
   input wire mem_select_in_n_i,
   input wire reset_n_o,
   input wire reset_o,
   input wire watchdog_expired_n_o,
   input wire power_fail_warn_n_o,
   input wire mem_select_gated_n_o
);
   localparam int REL_HI = P_STD_CYC + 6;
   logic [7:0] kst_q  = 8'h00;
   logic       kick_q = 1'b0;
   default clocking dc @(posedge sys_clk_i); endclocking
   default disable iff (!reset_n_i);
   ////////////////////////////////////////
   // cycles since the kick level last changed
   always @(posedge sys_clk_i)
   begin
      kick_q <= watchdog_kick_in_i;
      kst_q  <= (watchdog_kick_in_i != kick_q) ? 8'h00 : kst_q + {7'h00, kst_q != 8'hFF};
   end
   AST_PAIR: assert property (reset_o == !reset_n_o)
      else $error("reset pair");
   AST_FOLLOW: assert property (!supply_low_i && !backup_active_i
      |-> mem_select_gated_n_o == mem_select_in_n_i) else $error("select follow");
   AST_GATE: assert property (supply_low_i || backup_active_i |-> mem_select_gated_n_o)
      else $error("select gate");
   AST_WARN: assert property (power_fail_warn_n_o == !(power_fail_sense_in_i || backup_active_i))
      else $error("warn level");
   AST_HOLD: assert property (supply_low_i && $past(supply_low_i) |-> !reset_n_o)
      else $error("reset hold");
   AST_EXP_HIGH: assert property (supply_low_i && $past(supply_low_i) |-> watchdog_expired_n_o)
      else $error("expired high");
   AST_STRETCH: assert property ($fell(supply_low_i) && !backup_active_i |-> ##[1:REL_HI] reset_n_o)
      else $error("stretch");
   AST_EXP_HOLD: assert property (!watchdog_expired_n_o && kst_q > 8'h04 && !supply_low_i
      && !backup_active_i && !kick_floating_i |=> !watchdog_expired_n_o) else $error("expired hold");
   AST_FLOAT: assert property (kick_floating_i && $past(kick_floating_i) |-> !$fell(watchdog_expired_n_o))
      else $error("floating");
   AST_TMO: assert property ($fell(watchdog_expired_n_o) |-> kst_q >= 8'h30 ##[0:2] !reset_n_o)
      else $error("timeout");
   COV_TMO: cover property ($fell(watchdog_expired_n_o));
   COV_REL: cover property ($rose(reset_n_o));
   COV_BAK: cover property (backup_active_i && !power_fail_warn_n_o);
endmodule

// [tb/svwd_host.sv]
// host model: services the kick line or lets it float
`timescale 1ns/10ps
module svwd_host
#(
   parameter int PER = 30
)
(
   input  wire  sys_clk_i,
   input  wire  kick_en_i,
   input  wire  float_i,
   output logic kick_o
);
   int cnt = 0;
   initial kick_o = 1'b0;
   // toggle every PER cycles; a floating line sits at its pull-up
   always @(posedge sys_clk_i)
   begin
      cnt <= (cnt >= PER - 1) ? 0 : cnt + 1;
      if (float_i)
         kick_o <= 1'b1;
      else if (kick_en_i && cnt == 0)
         kick_o <= ~kick_o;
   end
endmodule

// [tb/svwd_top_test.sv]
// self-checking bench for the supervisor block
`timescale 1ns/10ps
module svwd_top_test;
   localparam int T = 200, TS = 50, P = 20;
   logic       clk = 0, rst_n = 0, kick_en = 0, flt = 0, sup = 0, bak = 0, pfs = 0, mem_select_in_n = 1;
   logic       tsel = 1, tin = 0, tshort = 0, wr = 0, rd = 0, rv = 0;
   logic [3:0] addr = 4'h0;
   logic [7:0] wd = 8'h00;
   wire        kick, rn, ro, watchdog_expired_n, power_fail_warn_n, ceo, irq, rn_l;
   wire  [7:0] rdata;
   logic [7:0] exq[$];
   int         err_total = 0, checks_done = 0, cyc_q = 0;
   integer     seed = 32'h512E452A;
   svwd_top #(.T_LONG_CYC(T), .T_SHORT_CYC(TS), .P_STD_CYC(P), .P_LONG_CYC(2 * P)) dut
   (
      .sys_clk_i(clk), .reset_n_i(rst_n), .clk_en_i(1'b1), .watchdog_kick_in_i(kick), .kick_floating_i(flt),
      .supply_low_i(sup), .backup_active_i(bak), .power_fail_sense_in_i(pfs), .mem_select_in_n_i(mem_select_in_n),
      .timebase_select_i(tsel), .timebase_input_i(tin), .timebase_strap_short_i(tshort), .reset_n_o(rn),
      .reset_o(ro), .watchdog_expired_n_o(watchdog_expired_n), .power_fail_warn_n_o(power_fail_warn_n), .mem_select_gated_n_o(ceo),
      .irq_o(irq), .reg_addr_i(addr), .reg_wdata_i(wd), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata)
   );
   // long-pulse variant beside the standard one, same stimulus
   svwd_top #(.LONG_PULSE(1), .T_LONG_CYC(T), .T_SHORT_CYC(TS), .P_STD_CYC(P), .P_LONG_CYC(2 * P)) dut_long
   (
      .sys_clk_i(clk), .reset_n_i(rst_n), .clk_en_i(1'b1), .watchdog_kick_in_i(kick), .kick_floating_i(flt),
      .supply_low_i(sup), .backup_active_i(bak), .power_fail_sense_in_i(pfs), .mem_select_in_n_i(mem_select_in_n),
      .timebase_select_i(tsel), .timebase_input_i(tin), .timebase_strap_short_i(tshort), .reset_n_o(rn_l),
      .reset_o(), .watchdog_expired_n_o(), .power_fail_warn_n_o(), .mem_select_gated_n_o(),
      .irq_o(), .reg_addr_i(addr), .reg_wdata_i(wd), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o()
   );
   svwd_host #(.PER(30)) host (.sys_clk_i(clk), .kick_en_i(kick_en), .float_i(flt), .kick_o(kick));
   ////////////////////////////////////////
   task test_done;
      if (err_total == 0 && checks_done > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task chk(input logic [7:0] seen, input logic [7:0] exp, input string nm);
      checks_done++;
      if (seen !== exp)
      begin
         err_total++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task wreg(input logic [3:0] a, input logic [7:0] d);
      addr <= a;
      wd <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task rreg(input logic [3:0] a, input logic [7:0] e);
      addr <= a;
      rd <= 1'b1;
      exq.push_back(e);
      @(posedge clk);
      rd <= 1'b0;
   endtask
   // stop kicking right after a kick edge
   task halt;
      @(kick);
      kick_en <= 1'b0;
   endtask
   // wait for reset level v and check the elapsed cycles
   task wrst(input int lo, input int hi, input logic v);
      int n;
      n = 0;
      while (rn !== v && n <= hi)
      begin
         @(posedge clk);
         n++;
      end
      chk(8'(n >= lo && n <= hi), 8'h01, "reset timing");
   endtask
   ////////////////////////////////////////
   // clock, random levels, external timebase, hang limit
   always #25 clk = ~clk;
   always @(posedge clk)
   begin
      mem_select_in_n <= 1'($random(seed));
      pfs <= (cyc_q < 300) ? 1'($random(seed)) : 1'b0;
      tin <= cyc_q[1];
      cyc_q <= cyc_q + 1;
      if (cyc_q == 40000)
      begin
         err_total++;
         test_done;
      end
   end
   // read data stand one cycle after the strobe
   always @(posedge clk)
   begin
      rv <= rd;
      if (rv)
         chk(rdata, exq.pop_front(), "rdata");
   end
   // main sequence
   initial
   begin
      cyc(16);
      rst_n <= 1'b1;
      wrst(P - 2, P + 6, 1'b1);
      chk(rn_l, 8'h00, "long stretch");
      sup <= 1'b1;
      cyc(5);
      chk(rn, 8'h00, "rst");
      chk(ro, 8'h01, "rst high");
      chk(ceo, 8'h01, "sel");
      chk(watchdog_expired_n, 8'h01, "expired");
      sup <= 1'b0;
      wrst(P - 2, P + 6, 1'b1);
      chk(rn_l, 8'h00, "long stretch");
      cyc(P + 2);
      chk(rn_l, 8'h01, "long stretch end");
      kick_en <= 1'b1;
      cyc(400);
      chk(rn, 8'h01, "kicked");
      chk(ceo, mem_select_in_n, "sel");
      rreg(4'h0, 8'h06);
      wreg(4'h0, 8'hFF);
      rreg(4'h0, 8'h00);
      wreg(4'hF, 8'hAA);
      rreg(4'hF, 8'h00);
      wreg(4'h1, 8'h01);
      rreg(4'h1, 8'h01);
      halt;
      wrst(T, T + 8, 1'b0);
      chk(watchdog_expired_n, 8'h00, "expired");
      cyc(1);
      chk(irq, 8'h01, "irq");
      rreg(4'h0, 8'h01);
      wrst(P - 4, P + 4, 1'b1);
      chk(rn_l, 8'h00, "long pulse");
      chk(watchdog_expired_n, 8'h00, "expired");
      wreg(4'h1, 8'h00);
      cyc(2);
      chk(irq, 8'h00, "irq masked");
      wrst(T - P - 4, T + 4, 1'b0);
      chk(rn_l, 8'h01, "long pulse end");
      wrst(P - 4, P + 4, 1'b1);
      kick_en <= 1'b1;
      cyc(40);
      chk(watchdog_expired_n, 8'h01, "expired");
      wreg(4'h1, 8'h01);
      cyc(2);
      chk(irq, 8'h01, "irq");
      wreg(4'h0, 8'h01);
      rreg(4'h0, 8'h00);
      chk(irq, 8'h00, "irq clear");
      tshort <= 1'b1;
      cyc(40);
      halt;
      wrst(TS, TS + 8, 1'b0);
      wrst(P - 4, P + 4, 1'b1);
      kick_en <= 1'b1;
      cyc(40);
      flt <= 1'b1;
      cyc(300);
      chk(rn, 8'h01, "floating");
      chk(watchdog_expired_n, 8'h01, "floating");
      rreg(4'h2, 8'h20);
      tsel <= 1'b0;
      kick_en <= 1'b0;
      flt <= 1'b0;
      wrst(4 * 4096 - 8, 4 * 4096 + 24, 1'b0);
      wrst(4 * 512 - 8, 4 * 512 + 8, 1'b1);
      wrst(4 * 1024 - 8, 4 * 1024 + 8, 1'b0);
      wrst(4 * 512 - 8, 4 * 512 + 8, 1'b1);
      kick_en <= 1'b1;
      bak <= 1'b1;
      sup <= 1'b1;
      cyc(4);
      chk(power_fail_warn_n, 8'h00, "warn");
      chk(ceo, 8'h01, "sel");
      chk(rn, 8'h00, "rst");
      bak <= 1'b0;
      sup <= 1'b0;
      wrst(P - 2, P + 6, 1'b1);
      test_done;
   end
endmodule
bind svwd_top svwd_props #(.P_STD_CYC((LONG_PULSE != 0) ? P_LONG_CYC : P_STD_CYC)) props
(
   .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .watchdog_kick_in_i(watchdog_kick_in_i),
   .kick_floating_i(kick_floating_i), .supply_low_i(supply_low_i), .backup_active_i(backup_active_i),
   .power_fail_sense_in_i(power_fail_sense_in_i), .mem_select_in_n_i(mem_select_in_n_i), .reset_n_o(reset_n_o),
   .reset_o(reset_o), .watchdog_expired_n_o(watchdog_expired_n_o), .power_fail_warn_n_o(power_fail_warn_n_o),
   .mem_select_gated_n_o(mem_select_gated_n_o)
);
